// file: design/twm_consts.vh
// constants for the two-wire memory slave interface
`ifndef TWM_CONSTS_VH
`define TWM_CONSTS_VH
`define TWM_ADDR_W 13
`define TWM_ADDR_ZERO 13'h0000
`define TWM_ADDR_LAST 13'h1fff
`define TWM_PROT_LO 13'h1800
`define TWM_BIT_CNT_W 4
`define TWM_BIT_LAST 4'h7
`define TWM_BIT_ACK 4'h8
`define TWM_BIT_ZERO 4'h0
`define TWM_DIR_BIT 0
`define TWM_SEL_HI 3
`define TWM_SEL_LO 1
`define TWM_TYPE_HI 7
`define TWM_TYPE_LO 4
`define TWM_HI_ADDR_BITS 4:0
`define TWM_ST_IDLE 3'h0
`define TWM_ST_DEVADR 3'h1
`define TWM_ST_ADRHI 3'h2
`define TWM_ST_ADRLO 3'h3
`define TWM_ST_WDATA 3'h4
`define TWM_ST_RDATA 3'h5
`endif

// file: design/twm_sync.v
// two-flop synchroniser for one external level
`timescale 1ns/100ps
`default_nettype none
module twm_sync #(
  parameter RESET_VAL = 1'b1
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // level in and out
  input wire din,
  output wire dout
);
  reg meta_reg;
  reg sync_reg;
  // first stage read only by second stage
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule // twm_sync
`default_nettype wire

// file: design/twm_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module twm_buf2 #(
  parameter WIDTH = 21
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire do_wr;
  wire do_rd;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  // storage holds no control state, so no reset
  always @(posedge clock) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  // pointers and occupancy
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (do_rd) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 2'h1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule // twm_buf2
`default_nettype wire

// file: design/twm_slave.v
// two-wire memory slave: protocol engine plus 8192-byte array
`timescale 1ns/100ps
`default_nettype none
`include "twm_consts.vh"
// Summary of operation
// - data line changes only while clock low, except start and stop
// - release data after eight bits; receiver pulls low in ninth clock
// - missing acknowledge aborts and returns to waiting for addressing
// - address bits 7-4 match type code, bits 3-1 match select pins
// - address bit 0 low means write, high means read
// - two address bytes, high first; top three high bits ignored
// - latch increments after each data byte, wraps 1fff to 0000
// - latch keeps value between transactions; reads start at latch
// - unlimited consecutive bytes per transaction
// - all bytes shifted most significant bit first
// - acknowledge each written byte for unprotected location
// - memory updated at eighth bit; earlier start or stop leaves it
// - no page buffer, no busy time; addressing always acknowledged
// - protect input high guards 1800 to 1fff from writes
// - protected byte not acknowledged, not stored, no increment
// - read data driven from latch address from next clock
// - master ack gives next byte; no ack ends read, releases line
// - random read: write address, repeated start, current read
// - start is data falling with clock high; stop is data rising
// - start always aborts and readies for a new slave address
// - stop aborts any operation in progress
module twm_slave #(
  parameter [3:0] DEV_TYPE = 4'h5, // arbitrary device type value
  parameter ADDR_W = `TWM_ADDR_W
) (
  // system clock and reset
  input wire clock,
  input wire resetn,
  // bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // straps
  input wire [2:0] chip_select_pins,
  input wire write_protect,
  // status
  output wire busy
);
  localparam MEM_DEPTH = 1 << ADDR_W;
  localparam CMD_W = ADDR_W + 8;
  reg [7:0] mem_reg [0:MEM_DEPTH-1];
  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] cs_s;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [4:0] addr_hi_reg;
  reg ack_pend_reg;
  reg drive_low_reg;
  reg rd_nack_reg;
  reg [7:0] rd_byte_reg;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire [7:0] shift_next;
  wire prot_hit;
  wire [ADDR_W-1:0] addr_inc;
  wire wq_valid;
  wire wq_ready;
  wire [CMD_W-1:0] wq_in;
  wire wq_out_valid;
  wire [CMD_W-1:0] wq_out;
  // pins pass two flops before use
  twm_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clock(clock), .resetn(resetn), .din(scl_in), .dout(scl_s));
  twm_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clock(clock), .resetn(resetn), .din(sda_in), .dout(sda_s));
  twm_sync #(.RESET_VAL(1'b1)) u_sync_wp (
    .clock(clock), .resetn(resetn), .din(write_protect), .dout(wp_s));
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cs
      twm_sync #(.RESET_VAL(1'b0)) u_sync_cs (
        .clock(clock), .resetn(resetn), .din(chip_select_pins[gi]), .dout(cs_s[gi]));
    end
  endgenerate
  // delayed copies for edge finding
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign shift_next = {shift_reg[6:0], sda_s};
  assign prot_hit = wp_s && (addr_reg >= `TWM_PROT_LO);
  // wrap from last to zero is an explicit compare against the last address
  assign addr_inc = (addr_reg == `TWM_ADDR_LAST) ? `TWM_ADDR_ZERO : addr_reg + 1'b1;
  // write path: stall cannot happen at bus rates, but a full buffer nacks
  assign wq_in = {addr_reg, shift_next};
  assign wq_valid = (state_reg == `TWM_ST_WDATA) && scl_rise && !ack_pend_reg &&
                    (bit_cnt_reg == `TWM_BIT_LAST) && !prot_hit;
  twm_buf2 #(.WIDTH(CMD_W)) u_wbuf (
    .clock(clock), .resetn(resetn),
    .in_valid(wq_valid), .in_ready(wq_ready), .in_data(wq_in),
    .out_valid(wq_out_valid), .out_ready(1'b1), .out_data(wq_out));
  // array write when eighth bit is in
  always @(posedge clock) begin
    if (wq_out_valid) begin
      mem_reg[wq_out[CMD_W-1:8]] <= wq_out[7:0];
    end
  end
  // protocol engine
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= `TWM_ST_IDLE;
      bit_cnt_reg <= `TWM_BIT_ZERO;
      shift_reg <= 8'h00;
      addr_reg <= `TWM_ADDR_ZERO;
      addr_hi_reg <= 5'h00;
      ack_pend_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      rd_nack_reg <= 1'b0;
      rd_byte_reg <= 8'hff;
    end else if (start_det) begin
      // start aborts; latch kept for following read
      state_reg <= `TWM_ST_DEVADR;
      bit_cnt_reg <= `TWM_BIT_ZERO;
      ack_pend_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= `TWM_ST_IDLE;
      bit_cnt_reg <= `TWM_BIT_ZERO;
      ack_pend_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        `TWM_ST_IDLE: begin
          drive_low_reg <= 1'b0;
        end
        `TWM_ST_DEVADR, `TWM_ST_ADRHI, `TWM_ST_ADRLO, `TWM_ST_WDATA: begin
          if (scl_rise && !ack_pend_reg) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `TWM_BIT_LAST) begin
              ack_pend_reg <= 1'b1;
              bit_cnt_reg <= `TWM_BIT_ZERO;
              case (state_reg)
                `TWM_ST_DEVADR: begin
                  // type and select match; always ready
                  if (shift_next[`TWM_TYPE_HI:`TWM_TYPE_LO] != DEV_TYPE ||
                      shift_next[`TWM_SEL_HI:`TWM_SEL_LO] != cs_s) begin
                    state_reg <= `TWM_ST_IDLE;
                    ack_pend_reg <= 1'b0;
                  end
                end
                `TWM_ST_ADRHI: begin
                  addr_hi_reg <= shift_next[`TWM_HI_ADDR_BITS];
                end
                `TWM_ST_ADRLO: begin
                  addr_reg <= {addr_hi_reg, shift_next};
                end
                `TWM_ST_WDATA: begin
                  // protected byte: no store, no increment, no ack
                  if (prot_hit || !wq_ready) begin
                    state_reg <= `TWM_ST_IDLE;
                    ack_pend_reg <= 1'b0;
                  end else begin
                    addr_reg <= addr_inc;
                  end
                end
                default: begin
                  state_reg <= `TWM_ST_IDLE;
                end
              endcase
            end
          end else if (scl_fall && ack_pend_reg && !drive_low_reg) begin
            drive_low_reg <= 1'b1;
          end else if (scl_fall && drive_low_reg) begin
            // ninth clock over: release (a read drives its first bit instead) and advance
            drive_low_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            case (state_reg)
              `TWM_ST_DEVADR: begin
                if (shift_reg[`TWM_DIR_BIT]) begin
                  state_reg <= `TWM_ST_RDATA;
                  rd_byte_reg <= mem_reg[addr_reg];
                  drive_low_reg <= !mem_reg[addr_reg][7];
                  bit_cnt_reg <= `TWM_BIT_ZERO;
                end else begin
                  state_reg <= `TWM_ST_ADRHI;
                end
              end
              `TWM_ST_ADRHI: state_reg <= `TWM_ST_ADRLO;
              `TWM_ST_ADRLO: state_reg <= `TWM_ST_WDATA;
              `TWM_ST_WDATA: state_reg <= `TWM_ST_WDATA;
              default: state_reg <= `TWM_ST_IDLE;
            endcase
          end
        end
        `TWM_ST_RDATA: begin
          // outgoing bits change on falling edge
          if (scl_rise && bit_cnt_reg == `TWM_BIT_ACK) begin
            rd_nack_reg <= sda_s;
          end else if (scl_rise && bit_cnt_reg == `TWM_BIT_LAST) begin
            addr_reg <= addr_inc;
          end
          if (scl_fall) begin
            if (bit_cnt_reg == `TWM_BIT_LAST) begin
              drive_low_reg <= 1'b0;
              bit_cnt_reg <= `TWM_BIT_ACK;
            end else if (bit_cnt_reg == `TWM_BIT_ACK) begin
              if (rd_nack_reg) begin
                // no ack ends read, line released
                state_reg <= `TWM_ST_IDLE;
                drive_low_reg <= 1'b0;
              end else begin
                rd_byte_reg <= mem_reg[addr_reg];
                drive_low_reg <= !mem_reg[addr_reg][7];
              end
              bit_cnt_reg <= `TWM_BIT_ZERO;
            end else begin
              drive_low_reg <= !rd_byte_reg[3'h6 - bit_cnt_reg[2:0]];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= `TWM_ST_IDLE;
        end
      endcase
    end
  end
  // ack is sampled by the master; a nack from it ends read above
  // open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;
  assign busy = (state_reg != `TWM_ST_IDLE);
endmodule // twm_slave
`default_nettype wire

// file: verif/twm_slave_props.sv
// pin-level assertions for the two-wire memory slave
`timescale 1ns/100ps
`default_nettype none
module twm_slave_props (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // straps and status
  input wire logic [2:0] chip_select_pins,
  input wire logic write_protect,
  input wire logic busy
);
  reg scl_q_reg;
  reg [3:0] rises_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // start and stop as seen on the raw pins
  sequence start_cond;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence stop_cond;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  // clock rises while engaged; saturates so it never wraps below eight
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_q_reg <= 1'b1;
      rises_reg <= 4'h0;
    end else begin
      scl_q_reg <= scl_in;
      if (!busy) begin
        rises_reg <= 4'h0;
      end else if (scl_in && !scl_q_reg && rises_reg != 4'hf) begin
        rises_reg <= rises_reg + 4'h1;
      end
    end
  end
  a_oe_clock_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("drive changed while bus clock high");
  a_ack_after_byte: assert property ($rose(sda_oe) |-> rises_reg >= 4'h8)
    else $error("line driven before eight clock rises");
  a_drive_holds: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("drive shorter than one bit");
  a_release_holds: assert property ($fell(sda_oe) |-> !sda_oe [*6])
    else $error("release shorter than one bit");
  a_pull_low: assert property (sda_oe |-> !sda_out)
    else $error("driven level not low");
  a_start_wakes: assert property (start_cond |-> ##[1:8] busy)
    else $error("start did not wake the engine");
  a_stop_aborts: assert property (stop_cond |-> ##[1:8] !busy)
    else $error("stop did not return to idle");
  a_idle_quiet: assert property (!busy |-> !sda_oe)
    else $error("line driven while idle");
endmodule // twm_slave_props
`default_nettype wire

// file: verif/twm_master.sv
// bus master model: makes the bus clock, releases or pulls the data line
`timescale 1ns/100ps
`default_nettype none
module twm_master (
  // pacing clock
  input wire logic clock,
  // bus lines; sda_rel high lets the pull-up win
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  // bus idle: clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait n clocks, landing just after the edge
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task bit_xfer(input logic b, output logic s);
    scl = 1'b0;
    tick(2);
    sda_rel = b;
    tick(2);
    scl = 1'b1;
    tick(3);
    s = sda_line;
    tick(1);
  endtask
  task edge_cond(input logic first);
    logic s;
    bit_xfer(first, s);
    sda_rel = !first;
    tick(4);
  endtask
  // msb first, released in ninth clock
  task wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = !s;
  endtask
  // no ack on last wanted byte
  task rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(!more, s);
  endtask
endmodule // twm_master
`default_nettype wire

// file: verif/tb_two_wire_memory_slave_interface.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/100ps
`default_nettype none
module tb_two_wire_memory_slave_interface;
  // device type code for the bench, value arbitrary
  localparam logic [3:0] TC = 4'h9;
  localparam logic [2:0] CS = 3'h5;
  localparam logic [7:0] SA_W = {TC, CS, 1'b0};
  localparam logic [7:0] SA_R = {TC, CS, 1'b1};
  // rows: slave address byte beside whether it must be taken
  localparam logic [8:0] ROWS [6] = '{{SA_W, 1'b1}, {SA_R, 1'b1}, {TC, 3'h4, 2'h0},
    {TC, 3'h1, 2'h0}, {TC, 3'h7, 2'h0}, {~TC, CS, 2'h0}};
  localparam logic [7:0] WDAT [4] = '{8'ha1, 8'h5a, 8'hc3, 8'h3c};
  logic clock, resetn, write_protect, ack;
  logic [2:0] chip_select_pins;
  logic [7:0] rd;
  int failures, tests_run;
  wire logic scl, sda_rel, sda_oe, sda_out, busy;
  // open-drain data line with a pull-up
  wire logic sda_line = sda_rel && !(sda_oe && !sda_out);
  twm_slave #(.DEV_TYPE(TC)) dut (.clock(clock), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
    .write_protect(write_protect), .busy(busy));
  twm_master mst (.clock(clock), .scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wr(input logic [7:0] d, input logic exp);
    mst.wbyte(d, ack);
    check("ack", {7'h0, exp}, {7'h0, ack});
  endtask
  task rdb(input logic more, input logic [7:0] exp);
    mst.rbyte(more, rd);
    check("read data", exp, rd);
  endtask
  task sel(input logic [7:0] sa);
    mst.edge_cond(1'b1);
    wr(sa, 1'b1);
  endtask
  task set_addr(input logic [15:0] a);
    sel(SA_W);
    wr(a[15:8], 1'b1);
    wr(a[7:0], 1'b1);
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // watchdog far beyond the roughly 4400 clocks the run needs
  initial begin
    #500000;
    failures++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    write_protect = 1'b0;
    chip_select_pins = CS;
    repeat (3) @(posedge clock);
    #1 resetn = 1'b1;
    mst.tick(10);
    // wrap past the top; the high address bits are ignored
    set_addr(16'hfffe);
    for (int i = 0; i < 4; i++) wr(WDAT[i], 1'b1);
    mst.edge_cond(1'b0);
    set_addr(16'h1ffe);
    sel(SA_R);
    for (int i = 0; i < 3; i++) rdb(i < 2, WDAT[i]);
    mst.edge_cond(1'b0);
    sel(SA_R);
    rdb(1'b0, WDAT[3]);
    mst.edge_cond(1'b0);
    // row reads land on a written location, so the line never carries unknowns
    set_addr(16'h0000);
    mst.edge_cond(1'b0);
    for (int i = 0; i < 6; i++) begin
      mst.edge_cond(1'b1);
      wr(ROWS[i][8:1], ROWS[i][0]);
      if (ack && ROWS[i][1]) begin
        rdb(1'b0, WDAT[2]);
      end
      mst.edge_cond(1'b0);
    end
    // moved straps: new select value taken, old one refused
    chip_select_pins = 3'h2;
    mst.tick(4);
    mst.edge_cond(1'b1);
    wr({TC, 3'h2, 1'b0}, 1'b1);
    mst.edge_cond(1'b0);
    mst.edge_cond(1'b1);
    wr(SA_W, 1'b0);
    mst.edge_cond(1'b0);
    chip_select_pins = CS;
    mst.tick(4);
    // upper quadrant refused while protected, lower still writable
    set_addr(16'h17ff);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    mst.edge_cond(1'b0);
    write_protect = 1'b1;
    set_addr(16'h17ff);
    wr(8'h33, 1'b1);
    wr(8'h44, 1'b0);
    mst.edge_cond(1'b0);
    sel(SA_R);
    rdb(1'b0, 8'h22);
    mst.edge_cond(1'b0);
    set_addr(16'h17ff);
    sel(SA_R);
    rdb(1'b0, 8'h33);
    mst.edge_cond(1'b0);
    write_protect = 1'b0;
    // a start inside a data byte leaves memory and latch alone
    set_addr(16'h0100);
    wr(8'h3c, 1'b1);
    mst.edge_cond(1'b0);
    set_addr(16'h0100);
    for (int i = 0; i < 5; i++) mst.bit_xfer(1'b0, ack);
    sel(SA_R);
    rdb(1'b0, 8'h3c);
    mst.edge_cond(1'b0);
    mst.tick(20);
    conclude();
  end
endmodule // tb_two_wire_memory_slave_interface
bind twm_slave twm_slave_props chk (.clock(clock), .resetn(resetn), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
  .write_protect(write_protect), .busy(busy));
`default_nettype wire
